// ---- shared/adcrm_pkg.sv ----
//
// Contract
// - Two-byte reads drive all twelve lines.
// - Slow two-byte first read returns low byte.
// - High-byte read: no start, nibble low, MSBs.
// - Slow mode: top four lines carry MSBs.
// - ROM read starts conversion, returns previous result.
// - Next ROM read returns new result, restarts.
// - ROM two-byte first read returns old low byte.
// - ROM third read returns new low byte.
// - ROM two-byte: top four lines carry MSBs.
// - High-byte read keeps busy high.
// - Input sampled at read strobe falling edge.
// - Start needs all three low; no restart.
// - Busy low for whole conversion.
// - Busy high only after latches hold result.
package adcrm_pkg;

  // ******************************************************************
  // Widths and timing.
  // ******************************************************************
  localparam int unsigned ADCRM_RES_W = 12;
  localparam int unsigned ADCRM_CLK_NS = 20;
  // Conversion time in nanoseconds and its cycle count (rounded up).
  localparam int unsigned ADCRM_CONV_NS = 3000;
  localparam int unsigned ADCRM_CONV_CYC = (ADCRM_CONV_NS + ADCRM_CLK_NS - 1) / ADCRM_CLK_NS;
  localparam int unsigned ADCRM_CNT_W = 8;
  localparam logic [ADCRM_CNT_W-1:0] ADCRM_CONV_LAST = 8'(ADCRM_CONV_CYC - 1);
  localparam logic [ADCRM_RES_W-1:0] ADCRM_RESULT_RST = 12'h000;

  // Converter sequencing states.
  typedef enum logic {ADCRM_IDLE, ADCRM_CONV} adcrm_state_t;

endpackage : adcrm_pkg

// ---- logic/adcrm_ctrl.sv ----
`timescale 1ns/100ps
module adcrm_ctrl
  import adcrm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic high_byte_select,
  input wire logic [ADCRM_RES_W-1:0] sar_code,
  output logic busy_n,
  output logic [ADCRM_RES_W-1:0] data_out,
  output logic [ADCRM_RES_W-1:0] data_oe,
  output logic sample_hold
);

  // ******************************************************************
  // State.
  // ******************************************************************
  adcrm_state_t state_reg, state_next;
  logic [ADCRM_CNT_W-1:0] cnt_reg, cnt_next;
  logic [ADCRM_RES_W-1:0] result_reg, result_next;
  logic rd_act_reg, rd_act_next;
  logic busy_n_reg, busy_n_next;
  logic [ADCRM_RES_W-1:0] dout_reg, dout_next;
  logic oe_reg, oe_next;
  logic hold_reg, hold_next;
  logic read_act, start;

  // Output mux: low byte or zero-padded high nibble on the low lines.
  function automatic logic [ADCRM_RES_W-1:0] adcrm_mux(input logic [ADCRM_RES_W-1:0] r,
                                                        input logic hb);
    adcrm_mux = hb ? {r[11:8], 4'h0, r[11:8]} : r;
  endfunction : adcrm_mux

  assign read_act = !cs_n && !rd_n;
  // Start needs all three low, on the strobe's leading edge, and never while converting.
  assign start = read_act && !rd_act_reg && !high_byte_select && (state_reg == ADCRM_IDLE);

  // Next-state logic for conversion, latches and outputs.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    result_next = result_reg;
    busy_n_next = busy_n_reg;
    hold_next = hold_reg;
    rd_act_next = read_act;
    unique case (state_reg)
      ADCRM_IDLE: begin
        if (start) begin
          state_next = ADCRM_CONV;
          cnt_next = '0;
          busy_n_next = 1'b0;
          hold_next = 1'b1;
        end
      end
      ADCRM_CONV: begin
        if (cnt_reg == ADCRM_CONV_LAST) begin
          state_next = ADCRM_IDLE;
          result_next = sar_code;
          busy_n_next = 1'b1;
          hold_next = 1'b0;
        end else begin
          cnt_next = cnt_reg + 8'h01;
        end
      end
    endcase
    // Drive only while selected; bus shows latched (old) data until busy returns.
    oe_next = read_act;
    dout_next = adcrm_mux(result_next, high_byte_select);
  end

  // Registers.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ADCRM_IDLE;
      cnt_reg <= '0;
      result_reg <= ADCRM_RESULT_RST;
      rd_act_reg <= 1'b0;
      busy_n_reg <= 1'b1;
      dout_reg <= '0;
      oe_reg <= 1'b0;
      hold_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      result_reg <= result_next;
      rd_act_reg <= rd_act_next;
      busy_n_reg <= busy_n_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      hold_reg <= hold_next;
    end
  end

  assign busy_n = busy_n_reg;
  assign data_out = dout_reg;
  // Every output line shares the one registered enable, so all lines turn on and off together.
  for (genvar g = 0; g < ADCRM_RES_W; g++) begin : g_oe
    assign data_oe[g] = oe_reg;
  end
  assign sample_hold = hold_reg;

  // ******************************************************************
  // Checker helpers.
  // ******************************************************************
  // Counts the cycles for which busy has been low, so that the length of a
  // conversion can be asserted without a long repetition.
  logic [ADCRM_CNT_W-1:0] busy_len_reg, busy_len_next;

  // Next value of the busy-length counter.
  always_comb begin
    busy_len_next = busy_len_reg;
    if (busy_n_reg) begin
      busy_len_next = '0;
    end else begin
      busy_len_next = busy_len_reg + 8'h01;
    end
  end

  // Register of the busy-length counter.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy_len_reg <= '0;
    end else begin
      busy_len_reg <= busy_len_next;
    end
  end

  // ******************************************************************
  // Assertions.
  // ******************************************************************
  property p_busy_on_start;
    @(posedge clk_sys) disable iff (!rstn) start |=> !busy_n;
  endproperty
  a_busy_on_start: assert property (p_busy_on_start) else $error("busy not asserted");

  property p_hb_no_start;
    @(posedge clk_sys) disable iff (!rstn) (read_act && high_byte_select && busy_n) |=> busy_n;
  endproperty
  a_hb_no_start: assert property (p_hb_no_start) else $error("high read started conversion");

  property p_hb_format;
    @(posedge clk_sys) disable iff (!rstn)
      (read_act && high_byte_select) |=> (data_out[7:4] == 4'h0 && data_out[3:0] == data_out[11:8]);
  endproperty
  a_hb_format: assert property (p_hb_format) else $error("high byte format wrong");

  property p_msb_top;
    @(posedge clk_sys) disable iff (!rstn) data_oe[11] |-> data_out[11:8] == result_reg[11:8];
  endproperty
  a_msb_top: assert property (p_msb_top) else $error("msbs missing on top lines");

  property p_oe;
    @(posedge clk_sys) disable iff (!rstn) $past(read_act) == data_oe[0];
  endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong");

  property p_conv_len;
    @(posedge clk_sys) disable iff (!rstn) $fell(busy_n) |-> !busy_n [*8];
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("busy released early");

  property p_done;
    @(posedge clk_sys) disable iff (!rstn) $fell(busy_n) |-> ##[1:160] busy_n;
  endproperty
  a_done: assert property (p_done) else $error("conversion never ends");

  property p_result_at_busy;
    @(posedge clk_sys) disable iff (!rstn) $rose(busy_n) |-> result_reg == $past(sar_code);
  endproperty
  a_result_at_busy: assert property (p_result_at_busy) else $error("result not latched");

  property p_no_restart;
    @(posedge clk_sys) disable iff (!rstn) !busy_n && !$rose(busy_n) |-> !start;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("restart during conversion");

  // A conversion keeps busy low for exactly the conversion time.
  property p_conv_cycles;
    @(posedge clk_sys) disable iff (!rstn)
      $rose(busy_n) |-> busy_len_reg == ADCRM_CONV_LAST + 8'h01;
  endproperty
  a_conv_cycles: assert property (p_conv_cycles) else $error("conversion length wrong");

  // Busy stays low until the counter reaches its last cycle.
  property p_busy_held;
    @(posedge clk_sys) disable iff (!rstn)
      (!busy_n && cnt_reg != ADCRM_CONV_LAST) |=> !busy_n;
  endproperty
  a_busy_held: assert property (p_busy_held) else $error("busy dropped mid conversion");

  // A low-byte read shows the whole latched result on the lines.
  property p_low_format;
    @(posedge clk_sys) disable iff (!rstn)
      (read_act && !high_byte_select) |=> data_out == result_reg;
  endproperty
  a_low_format: assert property (p_low_format) else $error("low read data wrong");

  // The hold flag follows the converter's busy state.
  property p_hold_tracks_busy;
    @(posedge clk_sys) disable iff (!rstn)
      sample_hold == !busy_n;
  endproperty
  a_hold_tracks_busy: assert property (p_hold_tracks_busy) else $error("hold and busy differ");

  // A strobe held low starts nothing after its leading edge.
  property p_leading_edge;
    @(posedge clk_sys) disable iff (!rstn)
      (read_act && $past(read_act) && $past(rstn)) |-> !start;
  endproperty
  a_leading_edge: assert property (p_leading_edge) else $error("held strobe restarted");

  // Released select or strobe turns the drivers off.
  property p_oe_off;
    @(posedge clk_sys) disable iff (!rstn)
      (cs_n || rd_n) |=> !data_oe[0];
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("lines driven while released");

  // The latched result changes only as busy returns high.
  property p_result_only_at_end;
    @(posedge clk_sys) disable iff (!rstn)
      !$stable(result_reg) |-> $rose(busy_n);
  endproperty
  a_result_only_at_end: assert property (p_result_only_at_end) else $error("result moved early");

  // A high-byte read on an idle converter leaves the input tracking.
  property p_hb_idle_no_hold;
    @(posedge clk_sys) disable iff (!rstn)
      (read_act && high_byte_select && busy_n) |=> !sample_hold;
  endproperty
  a_hb_idle_no_hold: assert property (p_hb_idle_no_hold) else $error("high read held input");

  // Select and strobe low turn on every line.
  property p_oe_on;
    @(posedge clk_sys) disable iff (!rstn)
      read_act |=> data_oe == {ADCRM_RES_W{1'b1}};
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("lines not driven");

  // The idle state never shows busy.
  property p_idle_not_busy;
    @(posedge clk_sys) disable iff (!rstn)
      (state_reg == ADCRM_IDLE) |-> busy_n;
  endproperty
  a_idle_not_busy: assert property (p_idle_not_busy) else $error("busy while idle");

  // The converting state always shows busy.
  property p_conv_busy;
    @(posedge clk_sys) disable iff (!rstn)
      (state_reg == ADCRM_CONV) |-> !busy_n;
  endproperty
  a_conv_busy: assert property (p_conv_busy) else $error("not busy while converting");

  // The cycle counter never runs past its last value.
  property p_cnt_range;
    @(posedge clk_sys) disable iff (!rstn)
      cnt_reg <= ADCRM_CONV_LAST;
  endproperty
  a_cnt_range: assert property (p_cnt_range) else $error("cycle counter overran");

  // Busy falls only because a start was taken.
  property p_fall_needs_start;
    @(posedge clk_sys) disable iff (!rstn)
      $fell(busy_n) |-> $past(start);
  endproperty
  a_fall_needs_start: assert property (p_fall_needs_start) else $error("busy fell unasked");

  // A slow low read sees the new result as busy returns.
  property p_slow_new_data;
    @(posedge clk_sys) disable iff (!rstn)
      ($rose(busy_n) && $past(read_act && !high_byte_select)) |-> data_out == result_reg;
  endproperty
  a_slow_new_data: assert property (p_slow_new_data) else $error("new result not shown");

  // A start puts the input on hold.
  property p_start_holds;
    @(posedge clk_sys) disable iff (!rstn)
      start |=> sample_hold;
  endproperty
  a_start_holds: assert property (p_start_holds) else $error("input not held");

  // The top four lines carry the result's top bits in a high read.
  property p_hb_msb_top;
    @(posedge clk_sys) disable iff (!rstn)
      (read_act && high_byte_select) |=> data_out[11:8] == result_reg[11:8];
  endproperty
  a_hb_msb_top: assert property (p_hb_msb_top) else $error("msbs missing in high read");

  // A high read still drives the lines.
  property p_hb_driven;
    @(posedge clk_sys) disable iff (!rstn)
      (read_act && high_byte_select) |=> data_oe[0];
  endproperty
  a_hb_driven: assert property (p_hb_driven) else $error("high read not driven");

  // A start clears the cycle counter.
  property p_start_clears_cnt;
    @(posedge clk_sys) disable iff (!rstn)
      start |=> cnt_reg == '0;
  endproperty
  a_start_clears_cnt: assert property (p_start_clears_cnt) else $error("counter not cleared");

  // A high read is never taken as a start.
  property p_hb_never_starts;
    @(posedge clk_sys) disable iff (!rstn)
      (read_act && high_byte_select) |-> !start;
  endproperty
  a_hb_never_starts: assert property (p_hb_never_starts) else $error("high read started");

  // ******************************************************************
  // Coverage of the main scenarios.
  // ******************************************************************
  // Starts, ends, high reads, idle high reads and slow reads that wait out a conversion.
  c_start: cover property (@(posedge clk_sys) disable iff (!rstn) start);
  c_done: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(busy_n));
  c_hb: cover property (@(posedge clk_sys) disable iff (!rstn) read_act && high_byte_select);
  c_hb_idle: cover property (@(posedge clk_sys) disable iff (!rstn) read_act && high_byte_select && busy_n);
  c_slow_done: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(busy_n) && read_act);

endmodule : adcrm_ctrl

// ---- tb/adcrm_host.sv ----
`timescale 1ns/100ps
// ****************************************
// Host bus model for the converter reads.
// ****************************************
module adcrm_host (
  input wire logic clk_sys,
  input wire logic busy_n,
  output logic cs_n,
  output logic rd_n,
  output logic high_byte_select
);
  // Idle bus: select and strobe released high.
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    high_byte_select = 1'b0;
  end
  // Start a read, stalling on busy in slow mode, then sample settled.
  task automatic rd(input logic hb, input bit slow);
    int n;
    @(posedge clk_sys);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    high_byte_select <= hb;
    repeat (3) @(posedge clk_sys);
    n = 0;
    while (slow && busy_n !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    #1;
  endtask : rd
  // Release select and strobe, then let outputs follow.
  task automatic rel();
    @(posedge clk_sys);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : rel
endmodule : adcrm_host

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
// ****************************************
// Self-checking bench of the read control.
// ****************************************
module testbench;
  import adcrm_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] sar_code = 12'h000;
  logic cs_n, rd_n, high_byte_select, busy_n, sample_hold;
  logic [11:0] data_out, data_oe, code;
  logic [11:0] model_q[$];
  logic [31:0] seed = 32'h3c5e;
  int bad_count = 0;
  int tests_run = 0;
  always #10 clk_sys = ~clk_sys;
  adcrm_ctrl i_adcrm_ctrl (.clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n), .rd_n(rd_n),
    .high_byte_select(high_byte_select), .sar_code(sar_code), .busy_n(busy_n),
    .data_out(data_out), .data_oe(data_oe), .sample_hold(sample_hold));
  adcrm_host i_adcrm_host (.clk_sys(clk_sys), .busy_n(busy_n), .cs_n(cs_n), .rd_n(rd_n),
    .high_byte_select(high_byte_select));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  // Watchdog cuts a hang short.
  initial begin
    repeat (3000) @(posedge clk_sys);
    bad_count++;
    print_verdict();
  end
  // Main sequence: slow two-byte read, then ROM reads.
  initial begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    seed = lfsr(seed);
    code = seed[11:0];
    sar_code <= code;
    i_adcrm_host.rd(1'b0, 1'b1);
    check(data_out, code);
    check(data_oe, 12'hfff);
    i_adcrm_host.rel();
    check(data_oe, 12'h000);
    i_adcrm_host.rd(1'b1, 1'b0);
    check({11'h000, busy_n}, 12'h001);
    check(data_out, {code[11:8], 4'h0, code[11:8]});
    i_adcrm_host.rel();
    model_q.push_back(code);
    $display("slow two-byte test done");
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      seed = lfsr(seed);
      code = seed[11:0];
      sar_code <= code;
      i_adcrm_host.rd(1'b0, 1'b0);
      check(data_out, model_q[$]);
      check({10'h000, busy_n, sample_hold}, 12'h001);
      i_adcrm_host.rel();
      repeat (ADCRM_CONV_CYC + 50) @(posedge clk_sys);
      model_q.push_back(code);
    end
    $display("rom read test done");
    @(posedge clk_sys);
    seed = lfsr(seed);
    code = seed[11:0];
    sar_code <= code;
    i_adcrm_host.rd(1'b0, 1'b0);
    check(data_out, model_q[$]);
    i_adcrm_host.rel();
    repeat (ADCRM_CONV_CYC) @(posedge clk_sys);
    i_adcrm_host.rd(1'b1, 1'b0);
    check({11'h000, busy_n}, 12'h001);
    check(data_out, {code[11:8], 4'h0, code[11:8]});
    i_adcrm_host.rel();
    model_q.push_back(code);
    i_adcrm_host.rd(1'b0, 1'b0);
    check(data_out, model_q[$]);
    check({10'h000, busy_n, sample_hold}, 12'h001);
    i_adcrm_host.rel();
    repeat (ADCRM_CONV_CYC + 50) @(posedge clk_sys);
    $display("rom two-byte test done");
    print_verdict();
  end
endmodule : testbench
